// ### core/crd_register_decode.sv
// register window decode, port pin logic and memory selects
`timescale 1ns/1ps
`include "crd_defines.svh"

module crd_register_decode #(
    parameter logic [2:0] BOOT_REGION = 3'h2,
    parameter logic [2:0] SRAM_REGION = 3'h3
) (
    input wire logic CLK_SYS,
    input wire logic RESET,
    input wire crd_pkg::crd_config_t CONFIG,
    input wire crd_pkg::crd_host_t HOST,
    output logic [7:0] HOST_DATA_OUT,
    output logic HOST_DATA_OE,
    input wire logic LOGIC_CLOCK_PIN,
    input wire crd_pkg::crd_port_t PORT_IN,
    output crd_pkg::crd_port_t PORT_OUT,
    output crd_pkg::crd_port_t PORT_OE,
    output crd_pkg::crd_port_t PORT_FAST,
    input wire crd_pkg::crd_port_t INPUT_CELLS,
    input wire logic [7:0] CELLS_AB_D,
    input wire logic [7:0] CELLS_BC_D,
    output logic [7:0] CELLS_AB,
    output logic [7:0] CELLS_BC,
    output logic LOGIC_CLOCK_TICK,
    input wire logic [7:0] MAIN_FLASH_LOCK,
    input wire logic [7:0] BOOT_FLASH_LOCK,
    output logic [7:0] POWER_CONTROL_FIRST,
    output logic [7:0] POWER_CONTROL_SECOND,
    output logic [7:0] TEST_PORT_ENABLE,
    output logic [7:0] MAIN_FLASH_SEL,
    output logic [3:0] BOOT_FLASH_SEL,
    output logic SRAM_SEL,
    output logic MEMORY_POWER_DOWN
);
    import crd_pkg::*;

    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (RESET);

    // main flash owns the upper half, so the other regions must sit low
    if (BOOT_REGION[2] || SRAM_REGION[2] || BOOT_REGION == SRAM_REGION) begin : g_bad_map
        $error("boot and sram regions must be distinct and below 3'h4");
    end

    crd_state_t st_reg;
    crd_state_t st_next;

    logic [15:0] acc_addr;
    logic cs_block;
    logic be_ok;
    logic win_hit;
    logic rd_hit;
    logic wr_rise;
    logic ale_fall;
    logic lclk_rise;
    logic [7:0] ofs;

    always_comb begin
        acc_addr = (st_reg.s2.host.address_latch_strobe == 1'b0 && CONFIG.bus_mode != CRD_BUS_NON_MUX)
            ? st_reg.lat_addr : st_reg.s2.host.addr;
        if (CONFIG.bus_mode != CRD_BUS_NON_MUX) begin
            acc_addr = st_reg.lat_addr;
        end
        ofs = acc_addr[7:0];
        cs_block = CONFIG.chip_select_used & st_reg.s2.host.chip_select_n;
        be_ok = ~CONFIG.byte_lane_used | ~st_reg.s2.host.byte_lane_enable_n;
        win_hit = (acc_addr[15:8] == CONFIG.window_base) & ~cs_block & be_ok;
        rd_hit = win_hit & ~st_reg.s2.host.rd_n;
        // write takes effect as the strobe returns high, when data is settled
        wr_rise = ~st_reg.wr_prev & st_reg.s2.host.wr_n & win_hit;
        ale_fall = st_reg.ale_prev & ~st_reg.s2.host.address_latch_strobe;
        lclk_rise = CONFIG.logic_clock_used & st_reg.s2.logic_clock_pin & ~st_reg.lclk_prev;
    end

    function automatic logic [7:0] read_mux(input crd_state_t s, input logic [7:0] o,
        input crd_port_t icell, input logic [7:0] mlock, input logic [7:0] block);
        logic [7:0] r;
        r = `CRD_UNMAPPED_READ;
        case (o)
            `CRD_OFS_A_IN: r = s.s2.pins[0];
            `CRD_OFS_B_IN: r = s.s2.pins[1];
            `CRD_OFS_C_IN: r = s.s2.pins[2];
            `CRD_OFS_D_IN: r = s.s2.pins[3];
            `CRD_OFS_A_CTRL: r = s.ctrl_a;
            `CRD_OFS_B_CTRL: r = s.ctrl_b;
            `CRD_OFS_A_OUT: r = s.out_v[0];
            `CRD_OFS_B_OUT: r = s.out_v[1];
            `CRD_OFS_C_OUT: r = s.out_v[2];
            `CRD_OFS_D_OUT: r = s.out_v[3];
            `CRD_OFS_A_DIR: r = s.dir[0];
            `CRD_OFS_B_DIR: r = s.dir[1];
            `CRD_OFS_C_DIR: r = s.dir[2];
            `CRD_OFS_D_DIR: r = s.dir[3];
            `CRD_OFS_A_DRV: r = s.drv[0];
            `CRD_OFS_B_DRV: r = s.drv[1];
            `CRD_OFS_C_DRV: r = s.drv[2];
            `CRD_OFS_D_DRV: r = s.drv[3];
            `CRD_OFS_A_ICELL: r = icell[0];
            `CRD_OFS_B_ICELL: r = icell[1];
            `CRD_OFS_C_ICELL: r = icell[2];
            `CRD_OFS_A_OE: r = s.pin_oe[0];
            `CRD_OFS_B_OE: r = s.pin_oe[1];
            `CRD_OFS_C_OE: r = s.pin_oe[2];
            `CRD_OFS_D_OE: r = s.pin_oe[3];
            `CRD_OFS_CELLS_AB: r = s.cells_ab;
            `CRD_OFS_CELLS_BC: r = s.cells_bc;
            `CRD_OFS_MASK_AB: r = s.mask_ab;
            `CRD_OFS_MASK_BC: r = s.mask_bc;
            `CRD_OFS_PWR_FIRST: r = s.pwr_first;
            `CRD_OFS_PWR_SECOND: r = s.pwr_second;
            `CRD_OFS_MAIN_LOCK: r = mlock;
            `CRD_OFS_BOOT_LOCK: r = block;
            `CRD_OFS_TEST_EN: r = s.test_en;
            `CRD_OFS_PAGE: r = s.page;
            `CRD_OFS_SPACE: r = s.space;
            default: r = `CRD_UNMAPPED_READ;
        endcase
        return r;
    endfunction

    always_comb begin
        logic [7:0] wd;
        logic [7:0] addr_a;
        logic [7:0] addr_b;
        logic [7:0] avail_a;
        logic [7:0] use_addr;
        logic [7:0] val;
        logic [7:0] en;
        logic [7:0] od;
        logic main_ok;
        logic boot_ok;
        logic prog;
        wd = '0;
        addr_a = '0;
        addr_b = '0;
        avail_a = '0;
        use_addr = '0;
        val = '0;
        en = '0;
        od = '0;
        main_ok = 1'b0;
        boot_ok = 1'b0;
        prog = 1'b0;
        st_next = st_reg;
        st_next.s1 = {HOST, LOGIC_CLOCK_PIN, PORT_IN};
        st_next.s2 = st_reg.s1;
        st_next.wr_prev = st_reg.s2.host.wr_n;
        st_next.ale_prev = st_reg.s2.host.address_latch_strobe;
        st_next.lclk_prev = st_reg.s2.logic_clock_pin;
        if (ale_fall) begin
            st_next.lat_addr = st_reg.s2.host.addr;
        end

        // logic clock loads the cells; a host write below overrides unmasked bits
        st_next.tick = lclk_rise;
        if (lclk_rise) begin
            st_next.cells_ab = CELLS_AB_D;
            st_next.cells_bc = CELLS_BC_D;
        end

        wd = st_reg.s2.host.data;
        if (wr_rise) begin
            case (ofs)
                `CRD_OFS_A_CTRL: st_next.ctrl_a = wd;
                `CRD_OFS_B_CTRL: st_next.ctrl_b = wd;
                `CRD_OFS_A_OUT: st_next.out_v[0] = wd;
                `CRD_OFS_B_OUT: st_next.out_v[1] = wd;
                `CRD_OFS_C_OUT: st_next.out_v[2] = wd;
                `CRD_OFS_D_OUT: st_next.out_v[3] = wd;
                `CRD_OFS_A_DIR: st_next.dir[0] = wd;
                `CRD_OFS_B_DIR: st_next.dir[1] = wd;
                `CRD_OFS_C_DIR: st_next.dir[2] = wd;
                `CRD_OFS_D_DIR: st_next.dir[3] = wd;
                `CRD_OFS_A_DRV: st_next.drv[0] = wd;
                `CRD_OFS_B_DRV: st_next.drv[1] = wd;
                `CRD_OFS_C_DRV: st_next.drv[2] = wd;
                `CRD_OFS_D_DRV: st_next.drv[3] = wd;
                `CRD_OFS_CELLS_AB: begin
                    st_next.cells_ab = (st_next.cells_ab & st_reg.mask_ab) | (wd & ~st_reg.mask_ab);
                end
                `CRD_OFS_CELLS_BC: begin
                    st_next.cells_bc = (st_next.cells_bc & st_reg.mask_bc) | (wd & ~st_reg.mask_bc);
                end
                `CRD_OFS_MASK_AB: st_next.mask_ab = wd;
                `CRD_OFS_MASK_BC: st_next.mask_bc = wd;
                `CRD_OFS_PWR_FIRST: st_next.pwr_first = wd;
                `CRD_OFS_PWR_SECOND: st_next.pwr_second = wd;
                `CRD_OFS_TEST_EN: st_next.test_en = wd;
                `CRD_OFS_PAGE: st_next.page = wd;
                `CRD_OFS_SPACE: st_next.space = wd;
                default: st_next.test_en = st_reg.test_en;
            endcase
        end

        // read data is registered; writes to read-only offsets fall to default
        st_next.rd_oe = rd_hit;
        st_next.rdata = rd_hit ? read_mux(st_reg, ofs, INPUT_CELLS, MAIN_FLASH_LOCK, BOOT_FLASH_LOCK)
            : st_reg.rdata;

        // address sources per host style, latched except on the non-mux bus
        case (CONFIG.bus_mode)
            CRD_BUS_MUX_GENERIC: begin
                addr_a = st_reg.lat_addr[7:0];
                addr_b = st_reg.lat_addr[7:0];
                avail_a = 8'hff;
            end
            CRD_BUS_NON_MUX: begin
                addr_b = st_reg.s2.host.addr[7:0];
                avail_a = 8'h00;
            end
            CRD_BUS_PAGE_MODE: begin
                addr_b = st_reg.lat_addr[15:8];
                avail_a = 8'h00;
            end
            default: begin
                avail_a = 8'h00;
            end
        endcase

        for (int p = 0; p < 4; p++) begin
            use_addr = (p == 0) ? (st_reg.ctrl_a & avail_a) : (p == 1) ? st_reg.ctrl_b : 8'h00;
            val = (use_addr & ((p == 0) ? addr_a : addr_b)) | (~use_addr & st_reg.out_v[p]);
            en = use_addr | st_reg.dir[p];
            od = (p < 2) ? (st_reg.drv[p] & `CRD_AB_OPEN_DRAIN_MASK) : st_reg.drv[p];
            st_next.pin_out[p] = val;
            // open drain only pulls low, so a high bit releases the pin
            st_next.pin_oe[p] = en & ~(od & val);
            st_next.pin_fast[p] = (p < 2) ? (st_reg.drv[p] & `CRD_AB_SLEW_MASK) : 8'h00;
        end

        // memory selects; the register window shadows memory
        prog = ~st_reg.s2.host.psen_n;
        main_ok = prog ? st_reg.space[`CRD_SPACE_MAIN_PROG] : st_reg.space[`CRD_SPACE_MAIN_DATA];
        boot_ok = prog ? st_reg.space[`CRD_SPACE_BOOT_PROG] : st_reg.space[`CRD_SPACE_BOOT_DATA];
        st_next.mem_pd = cs_block;
        st_next.main_sel = '0;
        st_next.boot_sel = '0;
        st_next.sram_sel = 1'b0;
        if (!cs_block && acc_addr[15:8] != CONFIG.window_base) begin
            if (acc_addr[15] && main_ok) begin
                st_next.main_sel = 8'h01 << st_reg.page[2:0];
            end
            if (acc_addr[15:13] == BOOT_REGION && boot_ok) begin
                st_next.boot_sel = 4'h1 << acc_addr[12:11];
            end
            if (acc_addr[15:13] == SRAM_REGION && !prog) begin
                st_next.sram_sel = 1'b1;
            end
        end
    end

    always_ff @(posedge CLK_SYS or posedge RESET) begin
        if (RESET) begin
            st_reg <= '0;
            // strobes start at their idle high level, so no false edge follows reset
            st_reg.wr_prev <= 1'b1;
            st_reg.s1.host.wr_n <= 1'b1;
            st_reg.s2.host.wr_n <= 1'b1;
            st_reg.s1.host.rd_n <= 1'b1;
            st_reg.s2.host.rd_n <= 1'b1;
        end else begin
            st_reg <= st_next;
        end
    end

    assign HOST_DATA_OUT = st_reg.rdata;
    assign HOST_DATA_OE = st_reg.rd_oe;
    assign PORT_OUT = st_reg.pin_out;
    assign PORT_OE = st_reg.pin_oe;
    assign PORT_FAST = st_reg.pin_fast;
    assign CELLS_AB = st_reg.cells_ab;
    assign CELLS_BC = st_reg.cells_bc;
    assign LOGIC_CLOCK_TICK = st_reg.tick;
    assign POWER_CONTROL_FIRST = st_reg.pwr_first;
    assign POWER_CONTROL_SECOND = st_reg.pwr_second;
    assign TEST_PORT_ENABLE = st_reg.test_en;
    assign MAIN_FLASH_SEL = st_reg.main_sel;
    assign BOOT_FLASH_SEL = st_reg.boot_sel;
    assign SRAM_SEL = st_reg.sram_sel;
    assign MEMORY_POWER_DOWN = st_reg.mem_pd;

    chk_read_needs_hit: assert property (
        HOST_DATA_OE |-> $past(!st_reg.s2.host.rd_n && acc_addr[15:8] == CONFIG.window_base && !cs_block && be_ok))
        else $error("read driven outside window");
    chk_pin_input_read: assert property (
        rd_hit && ofs == `CRD_OFS_A_IN |=> HOST_DATA_OUT == $past(st_reg.s2.pins[0]))
        else $error("pin input read wrong");
    chk_output_write: assert property (
        wr_rise && ofs == `CRD_OFS_A_OUT |=> st_reg.out_v[0] == $past(st_reg.s2.host.data))
        else $error("output register not loaded");
    chk_mask_holds: assert property (
        wr_rise && ofs == `CRD_OFS_CELLS_AB && !lclk_rise
        |=> (CELLS_AB & $past(st_reg.mask_ab)) == ($past(CELLS_AB) & $past(st_reg.mask_ab)))
        else $error("masked cell bit changed");
    chk_cs_blocks: assert property (cs_block |=> !HOST_DATA_OE && MEMORY_POWER_DOWN && SRAM_SEL == 1'b0)
        else $error("access while deselected");
    chk_enable_readback: assert property (
        rd_hit && ofs == `CRD_OFS_B_OE |=> HOST_DATA_OUT == $past(PORT_OE[1]))
        else $error("enable state read wrong");
    chk_lock_readback: assert property (
        rd_hit && ofs == `CRD_OFS_MAIN_LOCK |=> HOST_DATA_OUT == $past(MAIN_FLASH_LOCK))
        else $error("lock status read wrong");
    chk_ale_capture: assert property (ale_fall |=> st_reg.lat_addr == $past(st_reg.s2.host.addr))
        else $error("address not latched");
    chk_nonmux_port_a: assert property (
        CONFIG.bus_mode == CRD_BUS_NON_MUX ##1 CONFIG.bus_mode == CRD_BUS_NON_MUX
        |-> PORT_OUT[0] == $past(st_reg.out_v[0]))
        else $error("port a gave address on non-mux host");
    chk_generic_port_a: assert property (
        CONFIG.bus_mode == CRD_BUS_MUX_GENERIC && st_reg.ctrl_a == 8'hff
        |=> PORT_OUT[0] == $past(st_reg.lat_addr[7:0]))
        else $error("port a latched address wrong");
    chk_page_port_b: assert property (
        CONFIG.bus_mode == CRD_BUS_PAGE_MODE && st_reg.ctrl_b == 8'hff
        |=> PORT_OUT[1] == $past(st_reg.lat_addr[15:8]))
        else $error("port b page address wrong");
    chk_clock_tick: assert property (
        $rose(st_reg.s2.logic_clock_pin) && CONFIG.logic_clock_used
        |=> LOGIC_CLOCK_TICK ##1 !LOGIC_CLOCK_TICK)
        else $error("logic clock tick missing");
    chk_byte_gate: assert property (CONFIG.byte_lane_used && st_reg.s2.host.byte_lane_enable_n |=> !HOST_DATA_OE)
        else $error("byte enable ignored");
endmodule

// ### core/crd_defines.svh
// register window offsets, field masks and reset values
`ifndef CRD_DEFINES_SVH
`define CRD_DEFINES_SVH
`define CRD_WINDOW_BYTES 256
`define CRD_OFS_A_IN 8'h00
`define CRD_OFS_B_IN 8'h01
`define CRD_OFS_A_CTRL 8'h02
`define CRD_OFS_B_CTRL 8'h03
`define CRD_OFS_A_OUT 8'h04
`define CRD_OFS_B_OUT 8'h05
`define CRD_OFS_A_DIR 8'h06
`define CRD_OFS_B_DIR 8'h07
`define CRD_OFS_A_DRV 8'h08
`define CRD_OFS_B_DRV 8'h09
`define CRD_OFS_A_ICELL 8'h0a
`define CRD_OFS_B_ICELL 8'h0b
`define CRD_OFS_A_OE 8'h0c
`define CRD_OFS_B_OE 8'h0d
`define CRD_OFS_C_IN 8'h10
`define CRD_OFS_D_IN 8'h11
`define CRD_OFS_C_OUT 8'h12
`define CRD_OFS_D_OUT 8'h13
`define CRD_OFS_C_DIR 8'h14
`define CRD_OFS_D_DIR 8'h15
`define CRD_OFS_C_DRV 8'h16
`define CRD_OFS_D_DRV 8'h17
`define CRD_OFS_C_ICELL 8'h18
`define CRD_OFS_C_OE 8'h1a
`define CRD_OFS_D_OE 8'h1b
`define CRD_OFS_CELLS_AB 8'h20
`define CRD_OFS_CELLS_BC 8'h21
`define CRD_OFS_MASK_AB 8'h22
`define CRD_OFS_MASK_BC 8'h23
`define CRD_OFS_PWR_FIRST 8'hb0
`define CRD_OFS_PWR_SECOND 8'hb4
`define CRD_OFS_MAIN_LOCK 8'hc0
`define CRD_OFS_BOOT_LOCK 8'hc2
`define CRD_OFS_TEST_EN 8'hc7
`define CRD_OFS_PAGE 8'he0
`define CRD_OFS_SPACE 8'he2
`define CRD_AB_OPEN_DRAIN_MASK 8'hf0
`define CRD_AB_SLEW_MASK 8'h0f
`define CRD_SPACE_MAIN_PROG 0
`define CRD_SPACE_BOOT_PROG 1
`define CRD_SPACE_MAIN_DATA 2
`define CRD_SPACE_BOOT_DATA 3
`define CRD_REG_RESET 8'h00
`define CRD_UNMAPPED_READ 8'h00
`endif

// ### core/crd_pkg.sv
// types shared by the register window decode block
package crd_pkg;
    typedef logic [3:0][7:0] crd_port_t;

    typedef enum logic [1:0] {
        CRD_BUS_MUX_GENERIC = 2'h0,
        CRD_BUS_NON_MUX = 2'h1,
        CRD_BUS_PAGE_MODE = 2'h2
    } crd_bus_mode_t;

    typedef struct packed {
        logic [15:0] addr;
        logic [7:0] data;
        logic rd_n;
        logic wr_n;
        logic address_latch_strobe;
        logic chip_select_n;
        logic byte_lane_enable_n;
        logic psen_n;
    } crd_host_t;

    typedef struct packed {
        crd_bus_mode_t bus_mode;
        logic [7:0] window_base;
        logic chip_select_used;
        logic byte_lane_used;
        logic logic_clock_used;
    } crd_config_t;

    typedef struct packed {
        crd_host_t host;
        logic logic_clock_pin;
        crd_port_t pins;
    } crd_sync_t;

    typedef struct packed {
        crd_sync_t s1;
        crd_sync_t s2;
        logic wr_prev;
        logic ale_prev;
        logic lclk_prev;
        logic [15:0] lat_addr;
        logic [7:0] ctrl_a;
        logic [7:0] ctrl_b;
        crd_port_t out_v;
        crd_port_t dir;
        crd_port_t drv;
        crd_port_t pin_out;
        crd_port_t pin_oe;
        crd_port_t pin_fast;
        logic [7:0] cells_ab;
        logic [7:0] cells_bc;
        logic [7:0] mask_ab;
        logic [7:0] mask_bc;
        logic [7:0] pwr_first;
        logic [7:0] pwr_second;
        logic [7:0] test_en;
        logic [7:0] page;
        logic [7:0] space;
        logic [7:0] rdata;
        logic rd_oe;
        logic tick;
        logic [7:0] main_sel;
        logic [3:0] boot_sel;
        logic sram_sel;
        logic mem_pd;
    } crd_state_t;
endpackage

// ### verification/crd_host_model.sv
// partner model of the 8-bit host bus, multiplexed or not
`timescale 1ns/1ps
module crd_host_model (
    input wire logic CLK_SYS,
    input wire logic MUX,
    input wire logic [7:0] HOST_DATA_OUT,
    input wire logic HOST_DATA_OE,
    output crd_pkg::crd_host_t HOST
);
    import crd_pkg::*;
    logic cs_n = 1'b0;
    logic be_n = 1'b0;
    logic psen_n = 1'b1;
    initial begin
        HOST = '0;
        HOST.addr = 16'hffff;
        HOST.rd_n = 1'b1;
        HOST.wr_n = 1'b1;
        HOST.psen_n = 1'b1;
    end
    // select pins follow the bench between bus cycles
    always @(cs_n or be_n or psen_n) begin
        HOST.chip_select_n = cs_n;
        HOST.byte_lane_enable_n = be_n;
        HOST.psen_n = psen_n;
    end
    // multiplexed lines carry junk once the strobe has dropped
    task automatic put_addr(input logic [15:0] a);
        @(negedge CLK_SYS);
        HOST.addr = a;
        if (MUX) begin
            HOST.address_latch_strobe = 1'b1;
            repeat (4) @(negedge CLK_SYS);
            HOST.address_latch_strobe = 1'b0;
            repeat (3) @(negedge CLK_SYS);
            HOST.addr = ~a;
        end
    endtask
    task automatic bus_write(input logic [15:0] a, input logic [7:0] d);
        put_addr(a);
        HOST.data = d;
        HOST.wr_n = 1'b0;
        repeat (4) @(negedge CLK_SYS);
        HOST.wr_n = 1'b1;
        repeat (6) @(negedge CLK_SYS);
        HOST.data = ~d;
    endtask
    task automatic rd_begin(input logic [15:0] a);
        put_addr(a);
        HOST.rd_n = 1'b0;
        repeat (5) @(negedge CLK_SYS);
    endtask
    task automatic rd_end(output logic [7:0] d, output logic oe);
        d = HOST_DATA_OUT;
        oe = HOST_DATA_OE;
        HOST.rd_n = 1'b1;
        repeat (5) @(negedge CLK_SYS);
    endtask
    task automatic bus_read(input logic [15:0] a, output logic [7:0] d, output logic oe);
        rd_begin(a);
        rd_end(d, oe);
    endtask
endmodule

// ### verification/tb_top.sv
// self-checking bench for the register window decode block
`timescale 1ns/1ps
module tb_top;
    import crd_pkg::*;
    localparam logic [7:0] BASE = 8'h20;
    localparam logic [7:0] RWO [7] = '{8'hb0, 8'hb4, 8'hc7, 8'he0, 8'he2, 8'h22, 8'h23};
    localparam logic [7:0] OEO [4] = '{8'h0c, 8'h0d, 8'h1a, 8'h1b};
    localparam logic [7:0] ICO [3] = '{8'h0a, 8'h0b, 8'h18};
    localparam logic [15:0] SELA [3] = '{16'h8000, 16'h4800, 16'h6000};
    localparam logic [12:0] SELE [3] = '{13'h0100, 13'h0004, 13'h0001};
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic lclk = 1'b0;
    crd_config_t cfg;
    crd_host_t host_bus;
    crd_port_t port_in, icells, p_out, p_oe, p_fast;
    logic [7:0] rdata, nv, hdo, cab_d, cbc_d, cab, cbc, mlock, block, pwr1, pwr2, test_en, msel;
    logic [3:0] bsel;
    logic rd_oe, hoe, ssel, tick, mpd;
    logic [7:0] vals [7];
    logic [7:0] oa [4];
    int bad_count = 0;
    int cmp_count = 0;
    int seed = 62;
    int cycles = 0;
    int ticks = 0;

    crd_register_decode uut (.CLK_SYS(clk), .RESET(rst), .CONFIG(cfg), .HOST(host_bus),
        .HOST_DATA_OUT(hdo), .HOST_DATA_OE(hoe), .LOGIC_CLOCK_PIN(lclk), .PORT_IN(port_in),
        .PORT_OUT(p_out), .PORT_OE(p_oe), .PORT_FAST(p_fast), .INPUT_CELLS(icells),
        .CELLS_AB_D(cab_d), .CELLS_BC_D(cbc_d), .CELLS_AB(cab), .CELLS_BC(cbc),
        .LOGIC_CLOCK_TICK(tick), .MAIN_FLASH_LOCK(mlock), .BOOT_FLASH_LOCK(block),
        .POWER_CONTROL_FIRST(pwr1), .POWER_CONTROL_SECOND(pwr2), .TEST_PORT_ENABLE(test_en),
        .MAIN_FLASH_SEL(msel), .BOOT_FLASH_SEL(bsel), .SRAM_SEL(ssel), .MEMORY_POWER_DOWN(mpd));

    crd_host_model host (.CLK_SYS(clk), .MUX(cfg.bus_mode != CRD_BUS_NON_MUX),
        .HOST_DATA_OUT(hdo), .HOST_DATA_OE(hoe), .HOST(host_bus));

    initial begin
        forever #5 clk = ~clk;
    end

    always @(posedge clk) begin
        cycles++;
        if (tick === 1'b1) begin
            ticks++;
        end
        if (cycles == 20000) begin
            bad_count++;
            tally_and_finish;
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic tally_and_finish;
        if (bad_count == 0 && cmp_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic wr(input logic [7:0] o, input logic [7:0] d);
        host.bus_write({BASE, o}, d);
    endtask

    task automatic rd(input logic [7:0] o);
        host.bus_read({BASE, o}, rdata, rd_oe);
    endtask

    // open-drain bits release the pin while the value is high
    function automatic logic [7:0] exp_oe(input int p, input logic [7:0] o, input logic [7:0] dir,
                                          input logic [7:0] drv);
        logic [7:0] od;
        od = (p < 2) ? (drv & 8'hf0) : drv;
        return dir & ~(od & o);
    endfunction

    initial begin
        logic [7:0] d;
        logic [7:0] v;
        cfg = '{bus_mode: CRD_BUS_NON_MUX, window_base: BASE, chip_select_used: 1'b0,
                byte_lane_used: 1'b0, logic_clock_used: 1'b0};
        port_in = $random(seed);
        icells = $random(seed);
        cab_d = 8'($random(seed));
        cbc_d = 8'($random(seed));
        mlock = 8'($random(seed));
        block = 8'($random(seed));
        repeat (4) @(negedge clk);
        rst = 1'b0;
        repeat (2) @(negedge clk);
        for (int i = 0; i < 7; i++) begin
            rd(RWO[i]);
            check(rdata, 8'h00);
            vals[i] = 8'($random(seed));
            wr(RWO[i], vals[i]);
            rd(RWO[i]);
            check(rdata, vals[i]);
        end
        check(pwr1, vals[0]);
        check(pwr2, vals[1]);
        check(test_en, vals[2]);
        for (int p = 0; p < 4; p++) begin
            oa[p] = 8'($random(seed));
            d = 8'($random(seed));
            v = (p == 0) ? 8'hf0 : 8'($random(seed));
            wr(8'((p < 2) ? p : p + 12) + 8'h04, oa[p]);
            wr(8'((p < 2) ? p : p + 12) + 8'h06, d);
            wr(8'((p < 2) ? p : p + 12) + 8'h08, v);
            check(p_out[p], oa[p]);
            check(p_oe[p], exp_oe(p, oa[p], d, v));
            check(p_fast[p], (p < 2) ? (v & 8'h0f) : 8'h00);
            rd(OEO[p]);
            check(rdata, exp_oe(p, oa[p], d, v));
            rd(8'((p < 2) ? p : p + 14));
            check(rdata, port_in[p]);
        end
        for (int i = 0; i < 3; i++) begin
            rd(ICO[i]);
            check(rdata, icells[i]);
        end
        wr(8'hc0, ~mlock);
        rd(8'hc0);
        check(rdata, mlock);
        rd(8'hc2);
        check(rdata, block);
        wr(8'h30, 8'hff);
        rd(8'h30);
        check(rdata, 8'h00);
        wr(8'h22, 8'h0f);
        wr(8'h20, 8'hff);
        check(cab, 8'hf0);
        rd(8'h20);
        check(rdata, 8'hf0);
        wr(8'h23, 8'h00);
        wr(8'h21, 8'h5a);
        rd(8'h21);
        check(rdata, 8'h5a);
        cfg.logic_clock_used = 1'b1;
        ticks = 0;
        lclk = 1'b1;
        repeat (6) @(negedge clk);
        lclk = 1'b0;
        repeat (6) @(negedge clk);
        check(ticks, 1);
        check({cab, cbc}, {cab_d, cbc_d});
        cfg.bus_mode = CRD_BUS_MUX_GENERIC;
        wr(8'h02, 8'hff);
        wr(8'h03, 8'hff);
        check({p_out[1], p_out[0]}, 16'h0303);
        rd(8'h07);
        check({p_out[1], p_out[0]}, 16'h0707);
        cfg.bus_mode = CRD_BUS_NON_MUX;
        rd(8'h09);
        check({p_out[1], p_out[0]}, {8'h09, oa[0]});
        cfg.bus_mode = CRD_BUS_PAGE_MODE;
        rd(8'h0b);
        check({p_out[1], p_out[0]}, {BASE, oa[0]});
        cfg.bus_mode = CRD_BUS_NON_MUX;
        wr(8'h02, 8'h00);
        wr(8'h03, 8'h00);
        // refused accesses must leave the port C output untouched
        nv = ~oa[2];
        cfg.chip_select_used = 1'b1;
        cfg.byte_lane_used = 1'b1;
        host.cs_n = 1'b1;
        repeat (6) @(negedge clk);
        check(mpd, 1'b1);
        wr(8'h12, nv);
        rd(8'h12);
        check({rd_oe, p_out[2]}, {1'b0, oa[2]});
        host.cs_n = 1'b0;
        host.be_n = 1'b1;
        wr(8'h12, nv);
        check({mpd, p_out[2]}, {1'b0, oa[2]});
        host.be_n = 1'b0;
        host.bus_write({BASE + 8'h01, 8'h12}, nv);
        check(p_out[2], oa[2]);
        wr(8'h12, nv);
        rd(8'h12);
        check({p_out[2], rdata}, {nv, nv});
        wr(8'he0, 8'h03);
        wr(8'he2, 8'h0f);
        for (int i = 0; i < 3; i++) begin
            host.rd_begin(SELA[i]);
            check({msel, bsel, ssel}, SELE[i]);
            host.rd_end(rdata, rd_oe);
            check(rd_oe, 1'b0);
        end
        wr(8'he2, 8'h00);
        host.rd_begin(16'h8000);
        check(msel, 8'h00);
        host.rd_end(rdata, rd_oe);
        // program-space fetches: main flash placed in program space only, sram never
        wr(8'he2, 8'h01);
        host.psen_n = 1'b0;
        host.rd_begin(16'h8000);
        check(msel, 8'h08);
        host.rd_end(rdata, rd_oe);
        host.rd_begin(16'h6000);
        check(ssel, 1'b0);
        host.rd_end(rdata, rd_oe);
        host.psen_n = 1'b1;
        tally_and_finish;
    end
endmodule
